// >>> cbod_map.svh
// register offsets, field positions and reset values of the clock/buzzer output block
`ifndef CBOD_MAP_SVH
`define CBOD_MAP_SVH

// ==========================================================
// register addresses (processor data space)
`define CBOD_ADDR_W          20
`define CBOD_ADDR_SEL_CH0    20'hf_ffa5
`define CBOD_ADDR_SEL_CH1    20'hf_ffa6

// ==========================================================
// select register layout
`define CBOD_SEL_RESET       8'h00
`define CBOD_BIT_OUT_EN      7
`define CBOD_BIT_SRC_SEL     3
`define CBOD_CODE_MSB        2
`define CBOD_CODE_LSB        0
`define CBOD_FIXED_ZERO_MASK 8'h70

// ==========================================================
// divider exponents for the main clock, codes 0 to 7
`define CBOD_MAIN_EXP_0      4'h0
`define CBOD_MAIN_EXP_1      4'h1
`define CBOD_MAIN_EXP_2      4'h2
`define CBOD_MAIN_EXP_3      4'h3
`define CBOD_MAIN_EXP_4      4'h4
`define CBOD_MAIN_EXP_5      4'hb
`define CBOD_MAIN_EXP_6      4'hc
`define CBOD_MAIN_EXP_7      4'hd

// prescaler widths: largest main exponent, largest sub exponent
`define CBOD_MAIN_CNT_W      13
`define CBOD_SUB_CNT_W       7
`define CBOD_NUM_CH          2

`endif

// >>> cbod_pkg.sv
// types shared by the clock/buzzer output block
package cbod_pkg;

	// ==========================================================
	// source selected by the select register
	typedef enum logic {
		CBOD_SRC_MAIN = 1'b0,
		CBOD_SRC_SUB  = 1'b1
	} cbod_src_t;

	// ==========================================================
	// per-channel pin gating state
	typedef enum logic [1:0] {
		CBOD_ST_OFF   = 2'b00,
		CBOD_ST_RUN   = 2'b01,
		CBOD_ST_DRAIN = 2'b10
	} cbod_state_t;

endpackage : cbod_pkg

// >>> cbod_clock_out.sv
// two-channel clock/buzzer output divider with its select registers
//
// Summary of operation
// - each channel drives a square wave on its pin for a peripheral or buzzer
// - two channels, 0 and 1, each with its own select register and pin
// - select bit 7 enables the pin; zero disables it and is the default
// - bits 6 to 4 read zero; bit 3 picks the source; bits 2 to 0 the divider
// - main source codes divide by 1, 2, 4, 8, 16, 2048, 4096, 8192
// - subsystem source codes divide by 1 through 128 in powers of two
// - reset clears both select registers to zero: off, undivided main clock
// - select registers accept single-bit and whole-byte processor writes
// - subsystem-sourced output keeps running through stop mode
// - no subsystem output while low-power bit set and halted on subsystem clock
// - pin starts or stops only while the wave is low, up to half a period after the enable changes, never a short pulse
`timescale 1ns/1ps

`include "cbod_map.svh"

module cbod_clock_out (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	// processor register access
	input  wire logic [`CBOD_ADDR_W-1:0] cpu_addr,
	input  wire logic                    cpu_wr_byte,
	input  wire logic                    cpu_wr_bit,
	input  wire logic [2:0]              cpu_bit_idx,
	input  wire logic                    cpu_bit_val,
	input  wire logic [7:0]              cpu_wdata,
	input  wire logic                    cpu_rd,
	output logic      [7:0]              cpu_rdata,
	output logic                         cpu_rd_hit,
	// clock sources, sampled as synchronous levels
	input  wire logic                    main_clk_src,
	input  wire logic                    sub_clk_src,
	// power state of the chip
	input  wire logic                    stop_mode,
	input  wire logic                    halt_mode,
	input  wire logic                    cpu_on_sub_clk,
	input  wire logic                    subclock_low_power_bit,
	// pins and status
	output logic      [1:0]              tone_clock_pin,
	output logic      [1:0]              ch_active
);

	// ==========================================================
	// helper functions

	// is this address one of the two select registers
	function automatic logic cbod_hit(
		input logic [`CBOD_ADDR_W-1:0] addr
	);
		cbod_hit = (addr == `CBOD_ADDR_SEL_CH0) || (addr == `CBOD_ADDR_SEL_CH1);
	endfunction : cbod_hit

	// channel index of a hitting address
	function automatic logic cbod_ch(
		input logic [`CBOD_ADDR_W-1:0] addr
	);
		cbod_ch = (addr == `CBOD_ADDR_SEL_CH1);
	endfunction : cbod_ch

	// force the fixed-zero field of a select value
	function automatic logic [7:0] cbod_clean(
		input logic [7:0] v
	);
		cbod_clean = v & ~`CBOD_FIXED_ZERO_MASK;
	endfunction : cbod_clean

	// divider exponent for the main clock
	function automatic logic [3:0] cbod_main_exp(
		input logic [2:0] code
	);
		unique case (code)
			3'd0: cbod_main_exp = `CBOD_MAIN_EXP_0;
			3'd1: cbod_main_exp = `CBOD_MAIN_EXP_1;
			3'd2: cbod_main_exp = `CBOD_MAIN_EXP_2;
			3'd3: cbod_main_exp = `CBOD_MAIN_EXP_3;
			3'd4: cbod_main_exp = `CBOD_MAIN_EXP_4;
			3'd5: cbod_main_exp = `CBOD_MAIN_EXP_5;
			3'd6: cbod_main_exp = `CBOD_MAIN_EXP_6;
			3'd7: cbod_main_exp = `CBOD_MAIN_EXP_7;
		endcase
	endfunction : cbod_main_exp

	// divided main wave: exponent 0 follows the source itself,
	// exponent m takes prescaler bit m-1 (one toggle per 2^(m-1) edges)
	function automatic logic cbod_main_wave(
		input logic [2:0]                  code,
		input logic                        lvl,
		input logic [`CBOD_MAIN_CNT_W-1:0] cnt
	);
		logic [3:0] e;
		e = cbod_main_exp(code);
		if (e == 4'h0) begin
			cbod_main_wave = lvl;
		end else begin
			cbod_main_wave = cnt[e - 4'h1];
		end
	endfunction : cbod_main_wave

	// divided subsystem wave, exponent equals the code
	function automatic logic cbod_sub_wave(
		input logic [2:0]                 code,
		input logic                       lvl,
		input logic [`CBOD_SUB_CNT_W-1:0] cnt
	);
		if (code == 3'd0) begin
			cbod_sub_wave = lvl;
		end else begin
			cbod_sub_wave = cnt[code - 3'd1];
		end
	endfunction : cbod_sub_wave

	// ==========================================================
	// state

	logic [7:0]                  sel_ff     [`CBOD_NUM_CH];
	logic                        main_lvl_ff;
	logic                        sub_lvl_ff;
	logic [`CBOD_MAIN_CNT_W-1:0] main_cnt_ff;
	logic [`CBOD_SUB_CNT_W-1:0]  sub_cnt_ff;
	logic [1:0]                  wave_ff;
	cbod_pkg::cbod_state_t       state_ff   [`CBOD_NUM_CH];
	logic [1:0]                  pin_ff;
	logic [7:0]                  rdata_ff;
	logic                        rd_hit_ff;
	logic                        sub_prev_ff;
	logic [1:0]                  active_ff;

	logic                        main_run;
	logic                        sub_run;
	logic                        main_rise;
	logic                        sub_rise;
	logic [1:0]                  nxt_wave;

	// fixed-zero field as a vector so one bit can be picked out
	localparam logic [7:0] fixed_zero_mask = `CBOD_FIXED_ZERO_MASK;

	// ==========================================================
	// select registers

	// whole-byte and single-bit writes; bits 6..4 never store a one
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `CBOD_NUM_CH; i++) begin
				sel_ff[i] <= `CBOD_SEL_RESET;
			end
		end else if (cpu_wr_byte && cbod_hit(cpu_addr)) begin
			sel_ff[cbod_ch(cpu_addr)] <= cbod_clean(cpu_wdata);
		end else if (cpu_wr_bit && cbod_hit(cpu_addr)) begin
			sel_ff[cbod_ch(cpu_addr)][cpu_bit_idx] <= cpu_bit_val
				& ~fixed_zero_mask[cpu_bit_idx];
		end
	end

	// registered read; unmapped addresses return zero with no hit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_ff  <= 8'h00;
			rd_hit_ff <= 1'b0;
		end else if (cpu_rd && cbod_hit(cpu_addr)) begin
			rdata_ff  <= cbod_clean(sel_ff[cbod_ch(cpu_addr)]);
			rd_hit_ff <= 1'b1;
		end else begin
			rdata_ff  <= 8'h00;
			rd_hit_ff <= 1'b0;
		end
	end

	// ==========================================================
	// source gating in low-power modes

	// the main oscillator is stopped in stop mode, so its wave freezes;
	// software is expected to have disabled main-sourced channels first
	assign main_run = ~stop_mode;

	// the subsystem clock keeps running through stop mode, but is
	// withheld while halted on it with the low-power bit set
	assign sub_run = ~(subclock_low_power_bit && halt_mode && cpu_on_sub_clk);

	assign main_rise = main_run && main_clk_src && !main_lvl_ff;
	assign sub_rise  = sub_run && sub_clk_src && !sub_prev_ff;

	// ==========================================================
	// prescalers, shared by both channels

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			main_lvl_ff <= 1'b0;
			main_cnt_ff <= '0;
		end else begin
			if (main_run) begin
				main_lvl_ff <= main_clk_src;
			end
			if (main_rise) begin
				main_cnt_ff <= main_cnt_ff + `CBOD_MAIN_CNT_W'(1);
			end
		end
	end

	// edges are found on the raw level; the gated level reads low while
	// withheld and only rises on a real edge, so release gives no short phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sub_prev_ff <= 1'b0;
			sub_lvl_ff  <= 1'b0;
			sub_cnt_ff  <= '0;
		end else begin
			sub_prev_ff <= sub_clk_src;
			if (!sub_run || !sub_clk_src) begin
				sub_lvl_ff <= 1'b0;
			end else if (sub_rise) begin
				sub_lvl_ff <= 1'b1;
			end
			if (sub_rise) begin
				sub_cnt_ff <= sub_cnt_ff + `CBOD_SUB_CNT_W'(1);
			end
		end
	end

	// ==========================================================
	// per-channel wave selection

	always_comb begin
		for (int i = 0; i < `CBOD_NUM_CH; i++) begin
			if (cbod_pkg::cbod_src_t'(sel_ff[i][`CBOD_BIT_SRC_SEL]) == cbod_pkg::CBOD_SRC_SUB) begin
				nxt_wave[i] = cbod_sub_wave(sel_ff[i][`CBOD_CODE_MSB:`CBOD_CODE_LSB],
					sub_lvl_ff, sub_cnt_ff);
			end else begin
				nxt_wave[i] = cbod_main_wave(sel_ff[i][`CBOD_CODE_MSB:`CBOD_CODE_LSB],
					main_lvl_ff, main_cnt_ff);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wave_ff <= 2'b00;
		end else begin
			wave_ff <= nxt_wave;
		end
	end

	// ==========================================================
	// enable gating
	// the gate only opens or closes while the wave is low, so the pin
	// never shows a clipped high phase; the cost is up to half a period
	// of latency after the enable bit changes

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `CBOD_NUM_CH; i++) begin
				state_ff[i]  <= cbod_pkg::CBOD_ST_OFF;
				active_ff[i] <= 1'b0;
			end
		end else begin
			// the status flop is written with the state, so the port needs no decode
			for (int i = 0; i < `CBOD_NUM_CH; i++) begin
				unique case (state_ff[i])
					cbod_pkg::CBOD_ST_OFF: begin
						if (sel_ff[i][`CBOD_BIT_OUT_EN] && !wave_ff[i]) begin
							state_ff[i]  <= cbod_pkg::CBOD_ST_RUN;
							active_ff[i] <= 1'b1;
						end
					end
					cbod_pkg::CBOD_ST_RUN: begin
						if (!sel_ff[i][`CBOD_BIT_OUT_EN]) begin
							state_ff[i] <= wave_ff[i] ? cbod_pkg::CBOD_ST_DRAIN
								: cbod_pkg::CBOD_ST_OFF;
							active_ff[i] <= wave_ff[i];
						end
					end
					cbod_pkg::CBOD_ST_DRAIN: begin
						// finish the high phase already on the pin
						if (!wave_ff[i]) begin
							state_ff[i] <= sel_ff[i][`CBOD_BIT_OUT_EN] ? cbod_pkg::CBOD_ST_RUN
								: cbod_pkg::CBOD_ST_OFF;
							active_ff[i] <= sel_ff[i][`CBOD_BIT_OUT_EN];
						end
					end
					default: begin
						state_ff[i]  <= cbod_pkg::CBOD_ST_OFF;
						active_ff[i] <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// pin drivers

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_ff <= 2'b00;
		end else begin
			for (int i = 0; i < `CBOD_NUM_CH; i++) begin
				pin_ff[i] <= wave_ff[i] && (state_ff[i] != cbod_pkg::CBOD_ST_OFF);
			end
		end
	end

	assign tone_clock_pin = pin_ff;
	assign ch_active      = active_ff;
	assign cpu_rdata      = rdata_ff;
	assign cpu_rd_hit     = rd_hit_ff;

endmodule : cbod_clock_out

// >>> cbod_clock_out_sva.sv
// concurrent checks on the clock/buzzer output block ports
`timescale 1ns/1ps
`include "cbod_map.svh"
module cbod_clock_out_sva (
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input wire logic [`CBOD_ADDR_W-1:0] cpu_addr,
	input wire logic                    cpu_wr_byte,
	input wire logic                    cpu_wr_bit,
	input wire logic [7:0]              cpu_wdata,
	input wire logic                    cpu_rd,
	input wire logic [7:0]              cpu_rdata,
	input wire logic                    cpu_rd_hit,
	input wire logic [1:0]              tone_clock_pin,
	input wire logic [1:0]              ch_active
);
	logic mapped;
	logic ch0;
	assign ch0 = cpu_addr == `CBOD_ADDR_SEL_CH0;
	assign mapped = ch0 || cpu_addr == `CBOD_ADDR_SEL_CH1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// register port
	property p_rd_hit; cpu_rd && mapped |=> cpu_rd_hit; endproperty
	a_rd_hit: assert property (p_rd_hit) else $error("no read hit");
	property p_rd_miss; cpu_rd && !mapped |=> !cpu_rd_hit && cpu_rdata == 8'h00; endproperty
	a_rd_miss: assert property (p_rd_miss) else $error("unmapped read hit");
	property p_zero; cpu_rd_hit |-> cpu_rdata[6:4] == 3'h0; endproperty
	a_zero: assert property (p_zero) else $error("fixed bits set");
	// one idle cycle between the byte write and the read, with no other write
	property p_wr_rd;
		cpu_wr_byte && ch0 ##1 !cpu_wr_byte && !cpu_wr_bit ##1 cpu_rd && ch0
			|=> cpu_rdata == ($past(cpu_wdata, 3) & 8'h8f);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("readback differs");
	// ==========================================================
	// pins
	property p_rst; disable iff (1'b0) sys_rst |=> {tone_clock_pin, ch_active} == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("pins not cleared");
	// two cycles of margin: the pin register trails the gate by one clock
	property p_off_low;
		(~ch_active & ~$past(ch_active) & ~$past(ch_active, 2) & tone_clock_pin) == 2'h0;
	endproperty
	a_off_low: assert property (p_off_low) else $error("pin high while off");
	property p_no_short; $rose(tone_clock_pin[0]) |=> tone_clock_pin[0]; endproperty
	a_no_short: assert property (p_no_short) else $error("short pulse");
	property p_gated; $rose(tone_clock_pin[1]) |-> $past(ch_active[1]); endproperty
	a_gated: assert property (p_gated) else $error("rise without gate");
endmodule : cbod_clock_out_sva

bind cbod_clock_out cbod_clock_out_sva i_sva (
	.clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_wr_byte(cpu_wr_byte),
	.cpu_wr_bit(cpu_wr_bit),
	.cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rd_hit(cpu_rd_hit),
	.tone_clock_pin(tone_clock_pin), .ch_active(ch_active)
);

// >>> cbod_listener.sv
// far-side listener that times the high phase of one tone pin
`timescale 1ns/1ps
module cbod_listener (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic tone,
	output int        hi_len_ff,
	output int        pulses_ff
);
	int   run_ff;
	logic last_ff;
	// a part clocked by the pin only counts whole high phases
	always_ff @(posedge clk) begin
		last_ff <= tone & ~rst;
		run_ff <= (tone && !rst) ? run_ff + 1 : 0;
		if (rst) begin
			pulses_ff <= 0;
		end else if (last_ff && !tone) begin
			hi_len_ff <= run_ff;
			pulses_ff <= pulses_ff + 1;
		end
	end
endmodule : cbod_listener

// >>> cbod_clock_out_tb.sv
// self-checking bench for the clock/buzzer output block
`timescale 1ns/1ps
`include "cbod_map.svh"
module cbod_clock_out_tb;
	localparam logic [19:0] AD0 = `CBOD_ADDR_SEL_CH0;
	localparam logic [19:0] AD1 = `CBOD_ADDR_SEL_CH1;
	logic        clk = 1'b0, sys_rst = 1'b1, cpu_wr_byte = 1'b0, cpu_wr_bit = 1'b0;
	logic        cpu_bit_val = 1'b0, cpu_rd = 1'b0, main_clk_src = 1'b0, sub_clk_src = 1'b0;
	logic        stop_mode = 1'b0, halt_mode = 1'b0, cpu_on_sub_clk = 1'b0, low_pwr = 1'b0;
	logic [19:0] cpu_addr = 20'h0_0000;
	logic [2:0]  cpu_bit_idx = 3'h0;
	logic [7:0]  cpu_wdata = 8'h00, cpu_rdata;
	logic        cpu_rd_hit;
	logic [1:0]  tone_clock_pin, ch_active;
	int          hi_len [2];
	int          pulses [2];
	int          err_total = 0, checks = 0, hp = 4, mc = 0, sc = 0, k;
	int          exps [8] = '{0, 1, 2, 3, 4, 11, 12, 13};

	cbod_clock_out i_dut (.clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
		.cpu_wr_byte(cpu_wr_byte), .cpu_wr_bit(cpu_wr_bit), .cpu_bit_idx(cpu_bit_idx),
		.cpu_bit_val(cpu_bit_val), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
		.cpu_rdata(cpu_rdata), .cpu_rd_hit(cpu_rd_hit), .main_clk_src(main_clk_src),
		.sub_clk_src(sub_clk_src), .stop_mode(stop_mode), .halt_mode(halt_mode),
		.cpu_on_sub_clk(cpu_on_sub_clk), .subclock_low_power_bit(low_pwr),
		.tone_clock_pin(tone_clock_pin), .ch_active(ch_active));
	cbod_listener i_lsn0 (.clk(clk), .rst(sys_rst), .tone(tone_clock_pin[0]),
		.hi_len_ff(hi_len[0]), .pulses_ff(pulses[0]));
	cbod_listener i_lsn1 (.clk(clk), .rst(sys_rst), .tone(tone_clock_pin[1]),
		.hi_len_ff(hi_len[1]), .pulses_ff(pulses[1]));

	always #5 clk = ~clk;
	// main half period hp, sub half period 8 clocks
	always @(posedge clk) begin
		#1;
		mc = (mc >= hp - 1) ? 0 : mc + 1;
		if (mc == 0) main_clk_src = ~main_clk_src;
		sc = (sc + 1) % 8;
		if (sc == 0) sub_clk_src = ~sub_clk_src;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr_byte = 1'b1;
		@(posedge clk);
		#1 cpu_wr_byte = 1'b0;
		// one idle edge so a following call never re-raises the strobe in this step
		@(posedge clk);
		#1;
	endtask : wr
	task automatic wbit(input logic [19:0] a, input logic [2:0] i, input logic v);
		cpu_addr = a;
		cpu_bit_idx = i;
		cpu_bit_val = v;
		cpu_wr_bit = 1'b1;
		@(posedge clk);
		#1 cpu_wr_bit = 1'b0;
		@(posedge clk);
		#1;
	endtask : wbit
	task automatic rd(input logic [19:0] a, input logic [7:0] d, input logic h);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(posedge clk);
		#1 cpu_rd = 1'b0;
		cmp(cpu_rd_hit, h);
		cmp(cpu_rdata, d);
		@(posedge clk);
		#1;
	endtask : rd
	task automatic wait_pulse(input int ch, input int exp);
		int n;
		int j;
		n = pulses[ch];
		j = 0;
		while (pulses[ch] == n && j < 70000) begin
			@(posedge clk);
			#1 j++;
		end
		cmp(pulses[ch] - n, 1);
		cmp(hi_len[ch], exp);
	endtask : wait_pulse
	// the first pulse after enabling is measured, so a clipped start shows
	task automatic tone(input int ch, input logic [7:0] v, input int exp);
		int j;
		j = 0;
		wr(ch ? AD1 : AD0, v);
		wr(ch ? AD1 : AD0, v | 8'h80);
		wait_pulse(ch, exp);
		wr(ch ? AD1 : AD0, v);
		while (ch_active[ch] !== 1'b0 && j < 40000) begin
			@(posedge clk);
			#1 j++;
		end
		cmp(ch_active[ch], 1'b0);
		repeat (2) @(posedge clk);
		#1 cmp(tone_clock_pin[ch], 1'b0);
	endtask : tone
	task automatic results();
		$display("checks=%0d mismatches=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	initial begin
		// slowest main codes take about 3 high phases each, about 94k clocks at worst
		repeat (99000) @(posedge clk);
		err_total++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		rd(AD0, 8'h00, 1'b1);
		rd(AD1, 8'h00, 1'b1);
		cmp({ch_active, tone_clock_pin}, 4'h0);
		rd(20'hf_ffa7, 8'h00, 1'b0);
		$display("test reset done");
		wr(AD0, 8'hff);
		rd(AD0, 8'h8f, 1'b1);
		wbit(AD0, 3'h7, 1'b0);
		rd(AD0, 8'h0f, 1'b1);
		wbit(AD0, 3'h5, 1'b1);
		rd(AD0, 8'h0f, 1'b1);
		wr(20'hf_ffa7, 8'hff);
		wbit(AD1, 3'h2, 1'b1);
		rd(AD1, 8'h04, 1'b1);
		wr(AD0, 8'h00);
		wr(AD1, 8'h00);
		$display("test registers done");
		for (int c = 0; c < 8; c++) begin
			hp = (c < 5) ? 4 : 2;
			tone(0, 8'(c), hp << exps[c]);
		end
		for (int c = 0; c < 8; c++) begin
			tone(1, 8'h08 | 8'(c), 8 << c);
		end
		$display("test dividers done");
		wr(AD1, 8'h09);
		wr(AD1, 8'h89);
		stop_mode = 1'b1;
		wait_pulse(1, 16);
		halt_mode = 1'b1;
		cpu_on_sub_clk = 1'b1;
		low_pwr = 1'b1;
		repeat (40) @(posedge clk);
		#1 k = pulses[1];
		cmp(tone_clock_pin[1], 1'b0);
		repeat (200) @(posedge clk);
		#1 cmp(pulses[1] - k, 0);
		cmp(tone_clock_pin[1], 1'b0);
		low_pwr = 1'b0;
		wait_pulse(1, 16);
		stop_mode = 1'b0;
		$display("test low power done");
		wr(AD0, 8'h83);
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		rd(AD0, 8'h00, 1'b1);
		rd(AD1, 8'h00, 1'b1);
		cmp({ch_active, tone_clock_pin}, 4'h0);
		$display("test second reset done");
		results();
	end
endmodule : cbod_clock_out_tb
